// file: src/ascc_ctrl.sv
// Serial command port and configuration register control.
`timescale 1ns/10ps
`default_nettype none
module ascc_ctrl
    import ascc_pkg::*;
#(
    parameter int OSC_WAIT = OSC_START_CYC
) (
    // System clock and reset.
    input  wire logic      sys_clk,
    input  wire logic      rst_n,
    // Serial port; serial clock clocks the link domain.
    input  wire logic      sclk,
    input  wire logic      cs_n,
    input  wire logic      sdi,
    output logic           sdo_o,
    output logic           sdo_oe,
    // Oscillator source strap: high when an external clock is used.
    input  wire logic      ext_clk_sel,
    // Conversion engine side.
    input  wire logic [2:0] active_setup,
    input  wire logic [31:0] conv_data,
    output logic [1:0]     latch_output_pins,
    output logic           guard_drive,
    output ascc_ctl_t      ctl,
    output logic [1:0]     cal_sel
);
    // ---------------- Link domain (serial clock) ----------------
    logic        cs_act;
    logic [7:0]  cmd_r;
    logic [7:0]  sh_r;
    logic [5:0]  bcnt_r;
    logic [1:0]  widx_r;
    logic        in_data_r;
    logic        lead_seen_r;
    logic        flag_r;
    logic        wtog_r;
    logic        rtog_r;
    ascc_wr_t    wr_r;
    logic [31:0] din_r;
    logic [31:0] dout_r;
    logic        snap_r;
    logic [2:0]  grp_w;
    logic        is_rd_w;
    logic        array_w;
    logic [1:0]  nwords_w;
    logic [31:0] rd_word;
    // Marks that the last finished read was of the configuration register.
    logic        rd_cfg_r;

    assign cs_act = ~cs_n;
    assign grp_w   = cmd_r[2:0];
    assign is_rd_w = cmd_r[CMD_RW_BIT];
    assign array_w = cmd_r[CMD_ARRAY_BIT];
    assign nwords_w = array_w ? 2'(NREG - 1) : 2'h0;

    // Registers, read back directly across domains as a stable bus.
    logic [31:0] cfg_r;
    logic [31:0] ofs_r   [NREG];
    logic [31:0] gain_r  [NREG];
    logic [31:0] setup_r [NREG];

    function automatic logic [31:0] reg_pick(input logic [2:0] g, input logic [1:0] i,
                                             input logic [31:0] c, input logic [31:0] o,
                                             input logic [31:0] gn, input logic [31:0] s);
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (g)
            GRP_OFFSET: v = o;
            GRP_GAIN:   v = gn;
            GRP_CONFIG: v = c;
            GRP_SETUP:  v = s;
            default:    v = 32'h0000_0000;
        endcase
        return v;
    endfunction : reg_pick

    // The register arrays only change between words of a frame, so the
    // whole word is latched at the moment its first bit is due.
    assign rd_word = reg_pick(grp_w, widx_r, cfg_r, ofs_r[widx_r], gain_r[widx_r],
                              setup_r[widx_r]);

    // Command and data shifting, MSB first on the rising serial clock.
    // This domain takes the raw reset: the serial clock stands still while reset
    // is released. A soft reset leaves it alone, as a finished word already
    // returns the port to command mode.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            cmd_r       <= 8'h00;
            sh_r        <= 8'h00;
            bcnt_r      <= 6'h00;
            widx_r      <= 2'h0;
            in_data_r   <= 1'b0;
            lead_seen_r <= 1'b0;
            flag_r      <= 1'b0;
            wtog_r      <= 1'b0;
            rtog_r      <= 1'b0;
            din_r       <= 32'h0000_0000;
            wr_r        <= '0;
            rd_cfg_r    <= 1'b0;
        end else if (cs_act) begin
            if (!in_data_r) begin
                sh_r <= {sh_r[6:0], sdi};
                if (bcnt_r == 6'd7) begin
                    bcnt_r <= 6'h00;
                    unique case ({sh_r[6:0], sdi})
                        CMD_LEAD: lead_seen_r <= 1'b1;
                        CMD_END:  lead_seen_r <= 1'b0;
                        CMD_NULL: flag_r <= 1'b0;
                        default: begin
                            lead_seen_r <= 1'b0;
                            if (!sh_r[CMD_TOP_BIT - 1]) begin
                                cmd_r     <= {sh_r[6:0], sdi};
                                // The array bit of the arriving byte decides, not the old command.
                                widx_r    <= sh_r[CMD_ARRAY_BIT - 1] ? 2'h0
                                                                     : sh_r[CMD_CH_LSB:CMD_CH_LSB - 1];
                                in_data_r <= 1'b1;
                                flag_r    <= 1'b1;
                            end
                        end
                    endcase
                end else begin
                    bcnt_r <= bcnt_r + 6'h01;
                end
            end else begin
                din_r <= {din_r[30:0], sdi};
                if (bcnt_r == 6'd31) begin
                    bcnt_r <= 6'h00;
                    if (!is_rd_w) begin
                        wr_r   <= '{grp: grp_w, idx: widx_r, data: {din_r[30:0], sdi}};
                        wtog_r <= ~wtog_r;
                    end else begin
                        rtog_r <= ~rtog_r;
                        rd_cfg_r <= (grp_w == GRP_CONFIG);
                    end
                    if (!array_w || widx_r == nwords_w) begin
                        in_data_r <= 1'b0;
                    end else begin
                        widx_r <= widx_r + 2'h1;
                    end
                end else begin
                    bcnt_r <= bcnt_r + 6'h01;
                end
            end
        end
    end

    // Output shifter changes on the falling serial clock.
    // Each word is loaded on the falling edge just before its first rising edge.
    always_ff @(negedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            dout_r <= 32'h0000_0000;
            snap_r <= 1'b0;
        end else if (in_data_r && is_rd_w && cs_act) begin
            if (bcnt_r == 6'h00 && !snap_r) begin
                dout_r <= rd_word;
                snap_r <= 1'b1;
            end else begin
                dout_r <= {dout_r[30:0], 1'b0};
                snap_r <= (bcnt_r != 6'd31);
            end
        end else begin
            snap_r <= 1'b0;
        end
    end

    // The pin takes the shifter's top bit directly: a copy through the system
    // clock would miss bits, as half a serial period is shorter than a system period.
    assign sdo_o = dout_r[31];

    // ---------------- System domain ----------------
    logic       rst_m_r;
    logic       srst_n;
    logic       wtog_s;
    logic       wtog_d_r;
    logic       rtog_s;
    logic       rtog_d_r;
    logic       wr_evt;
    logic       rd_evt;
    ascc_pwr_t  pwr_r;
    logic [31:0] wait_r;
    logic [1:0] chan_sel;
    logic [31:0] setup_sel;
    logic       cs_s;
    logic       ext_s;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_r <= 1'b0;
            srst_n  <= 1'b0;
        end else begin
            rst_m_r <= 1'b1;
            srst_n  <= rst_m_r;
        end
    end

    // Each finished word flips a toggle; the word stays put until the next one
    // ends, so it is steady by the time the synchronised toggle is seen.
    ascc_sync #(.W(2)) u_tog_sys (
        .clk   (sys_clk),
        .rst_n (srst_n),
        .d     ({wtog_r, rtog_r}),
        .q     ({wtog_s, rtog_s})
    );

    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            wtog_d_r <= 1'b0;
            rtog_d_r <= 1'b0;
        end else begin
            wtog_d_r <= wtog_s;
            rtog_d_r <= rtog_s;
        end
    end
    assign wr_evt = wtog_s ^ wtog_d_r;
    assign rd_evt = (rtog_s ^ rtog_d_r) && rd_cfg_r;

    // Select and the clock strap are pins: two flip-flops before any use.
    ascc_sync #(.W(2)) u_pin_sys (
        .clk   (sys_clk),
        .rst_n (srst_n),
        .d     ({cs_act, ext_clk_sel}),
        .q     ({cs_s, ext_s})
    );

    // The data out pin is released within three system clocks of deselect.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            sdo_oe <= 1'b0;
        end else begin
            sdo_oe <= cs_s;
        end
    end

    // Configuration register.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            cfg_r <= CFG_RESET;
        end else if (wr_evt && wr_r.grp == GRP_CONFIG) begin
            if (wr_r.data[B_SRST]) begin
                // A reset write sets only the reset bit and the reset flag.
                cfg_r        <= CFG_RESET;
                cfg_r[B_SRST]  <= 1'b1;
                cfg_r[B_RDONE] <= 1'b1;
            end else begin
                cfg_r <= (wr_r.data & CFG_USED_MASK & ~(32'h1 << B_RDONE))
                       | ({31'h0, cfg_r[B_RDONE] & ~rd_evt} << B_RDONE);
            end
        end else if (rd_evt) begin
            cfg_r[B_RDONE] <= 1'b0;
        end
    end

    // Calibration and setup arrays.
    // A soft reset reloads them together with the configuration.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            for (int i = 0; i < NREG; i++) begin
                ofs_r[i]   <= OFS_RESET;
                gain_r[i]  <= GAIN_RESET;
                setup_r[i] <= SETUP_RESET;
            end
        end else if (wr_evt && wr_r.grp == GRP_CONFIG && wr_r.data[B_SRST]) begin
            for (int i = 0; i < NREG; i++) begin
                ofs_r[i]   <= OFS_RESET;
                gain_r[i]  <= GAIN_RESET;
                setup_r[i] <= SETUP_RESET;
            end
        end else if (wr_evt) begin
            unique case (wr_r.grp)
                GRP_OFFSET: ofs_r[wr_r.idx]   <= wr_r.data;
                GRP_GAIN:   gain_r[wr_r.idx]  <= wr_r.data;
                GRP_SETUP:  setup_r[wr_r.idx] <= wr_r.data;
                default:    ;
            endcase
        end
    end

    // Power-save state machine. Standby deepens to sleep once the save bit is set while power-down holds;
    // leaving sleep waits for the oscillator unless an external clock is used.
    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            pwr_r  <= ASCC_NORMAL;
            wait_r <= 32'h0000_0000;
        end else begin
            unique case (pwr_r)
                ASCC_NORMAL: if (cfg_r[B_PDOWN]) begin
                    pwr_r <= cfg_r[B_SAVE] ? ASCC_SLEEP : ASCC_STANDBY;
                end
                ASCC_STANDBY: if (!cfg_r[B_PDOWN]) begin
                    pwr_r <= ASCC_NORMAL;
                end else if (cfg_r[B_SAVE]) begin
                    pwr_r <= ASCC_SLEEP;
                end
                ASCC_SLEEP: if (!cfg_r[B_PDOWN]) begin
                    pwr_r  <= ext_s ? ASCC_NORMAL : ASCC_WAKING;
                    wait_r <= 32'(OSC_WAIT);
                end
                ASCC_WAKING: begin
                    if (wait_r <= 32'h0000_0001) begin
                        pwr_r <= ASCC_NORMAL;
                    end
                    wait_r <= wait_r - 32'h0000_0001;
                end
            endcase
        end
    end

    // Setup selection, calibration bank and latch outputs.
    // An odd setup sits in the low half of its register; it is moved up so
    // that one set of field positions serves both halves.
    assign setup_sel = active_setup[0] ? {setup_r[active_setup[2:1]][15:0], 16'h0000}
                                       : setup_r[active_setup[2:1]];
    assign chan_sel  = cfg_r[B_BANK] ? setup_sel[S_BANK_HI:S_BANK_LO]
                                     : setup_sel[S_CH_HI:S_CH_LO];

    always_ff @(posedge sys_clk or negedge srst_n) begin
        if (!srst_n) begin
            latch_output_pins <= 2'h0;
            guard_drive       <= 1'b0;
            ctl               <= '0;
            cal_sel           <= 2'h0;
        end else begin
            latch_output_pins <= cfg_r[B_LSRC] ? cfg_r[B_LAT_HI:B_LAT_LO]
                                               : setup_sel[S_LAT_HI:S_LAT_LO];
            if (cfg_r[B_GUARD]) begin
                latch_output_pins[0] <= 1'b0;
            end
            guard_drive    <= cfg_r[B_GUARD];
            cal_sel        <= chan_sel;
            ctl.in_ground  <= cfg_r[B_IGND];
            ctl.guard_on   <= cfg_r[B_GUARD];
            ctl.ref_range  <= cfg_r[B_REFR];
            ctl.rate_scale <= cfg_r[B_RATE];
            ctl.osc_bank   <= chan_sel;
            ctl.latch      <= cfg_r[B_LAT_HI:B_LAT_LO];
            ctl.sleep      <= (pwr_r == ASCC_SLEEP) || (pwr_r == ASCC_WAKING);
            ctl.standby    <= (pwr_r == ASCC_STANDBY);
        end
    end
endmodule : ascc_ctrl
`default_nettype wire

// file: src/ascc_pkg.sv
// Package with constants, types and commands of the serial command and configuration block.
// Behaviour
// - 0xFF then 0xFE realigns the serial port; code keeps its bit count and skips both
// - Zero byte clears port flag, nothing else
// - Data out undriven while chip select high; code releases it within three system clocks of deselect
// - Serial clock ignored while chip select high
// - Works with chip select tied low
// - Calibration, config, setup registers read and write
// - Command byte then 32 data bits
// - Single transfer returns port to command mode
// - Array commands move whole set in order
// - Config is 32 bits, unused bits zero
// - Power down enters standby or sleep
// - Sleep exit waits 20 ms oscillator start
// - Soft reset bit resets logic, sets flag
// - Reset flag read only, cleared by read
// - Reset loads zeros and unity gain default
// - Reset write sets only soft reset bit; code also sets reset flag
// - Input ground bit shorts all input pairs
// - Guard bit turns first latch pin guard
// - Latch pins follow setup or config bits
// - Bank choice picks channel or bank pointer
// - Rate scale bit selects five-sixths rates
// - Command bit three: zero write, one read
package ascc_pkg;
    localparam int          WORD_W        = 32;
    localparam int          NREG          = 4;
    localparam logic [7:0]  CMD_LEAD      = 8'hFF;
    localparam logic [7:0]  CMD_END       = 8'hFE;
    localparam logic [7:0]  CMD_NULL      = 8'h00;
    localparam logic [2:0]  GRP_OFFSET    = 3'h1;
    localparam logic [2:0]  GRP_GAIN      = 3'h2;
    localparam logic [2:0]  GRP_CONFIG    = 3'h3;
    localparam logic [2:0]  GRP_SETUP     = 3'h5;
    localparam int          CMD_RW_BIT    = 3;
    localparam int          CMD_ARRAY_BIT = 6;
    localparam int          CMD_CH_LSB    = 4;
    localparam int          CMD_TOP_BIT   = 7;
    localparam logic [31:0] CFG_RESET     = 32'h0000_0000;
    localparam logic [31:0] OFS_RESET     = 32'h0000_0000;
    localparam logic [31:0] GAIN_RESET    = 32'h0010_0000;
    localparam logic [31:0] SETUP_RESET   = 32'h0000_0000;
    localparam logic [31:0] CFG_USED_MASK = 32'hFFD8_0000;
    localparam int          B_SAVE        = 31;
    localparam int          B_PDOWN       = 30;
    localparam int          B_SRST        = 29;
    localparam int          B_RDONE       = 28;
    localparam int          B_IGND        = 27;
    localparam int          B_GUARD       = 26;
    localparam int          B_REFR        = 25;
    localparam int          B_LAT_HI      = 24;
    localparam int          B_LAT_LO      = 23;
    localparam int          B_LSRC        = 22;
    localparam int          B_BANK        = 20;
    localparam int          B_RATE        = 19;
    localparam int          S_CH_HI       = 31;
    localparam int          S_CH_LO       = 30;
    localparam int          S_LAT_HI      = 21;
    localparam int          S_LAT_LO      = 20;
    localparam int          S_BANK_HI     = 17;
    localparam int          S_BANK_LO     = 16;
    localparam int          SYS_CLK_HZ    = 25_000_000;
    localparam int          OSC_START_MS  = 20;
    localparam int          OSC_START_CYC = (SYS_CLK_HZ / 1000) * OSC_START_MS;

    typedef enum logic [1:0] {ASCC_NORMAL, ASCC_STANDBY, ASCC_SLEEP, ASCC_WAKING} ascc_pwr_t;

    // One complete word transfer handed from the link domain to the system domain.
    typedef struct packed {
        logic [2:0]  grp;
        logic [1:0]  idx;
        logic [31:0] data;
    } ascc_wr_t;

    // Analog control levels produced from the configuration.
    typedef struct packed {
        logic       in_ground;
        logic       guard_on;
        logic       ref_range;
        logic       rate_scale;
        logic [1:0] osc_bank;
        logic [1:0] latch;
        logic       sleep;
        logic       standby;
    } ascc_ctl_t;
endpackage : ascc_pkg

// file: src/ascc_sync.sv
// Two flip-flop level synchroniser.
`timescale 1ns/10ps
`default_nettype none
module ascc_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule : ascc_sync
`default_nettype wire

// file: testbench/ascc_checker.sv
// Port-level assertions of the serial command block.
`timescale 1ns/10ps
`default_nettype none
module ascc_checker
    import ascc_pkg::*;
#(
    parameter int OSC_WAIT = 10
) (
    // Clock and reset.
    input wire logic       sys_clk,
    input wire logic       rst_n,
    // Watched ports.
    input wire logic       cs_n,
    input wire logic [2:0] active_setup,
    input wire logic       sdo_oe,
    input wire logic [1:0] latch_output_pins,
    input wire logic [1:0] cal_sel,
    input wire logic       guard_drive,
    input wire ascc_ctl_t  ctl
);
    logic [2:0] setup_q_r;
    logic [3:0] idle_cnt_r;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            setup_q_r <= 3'h0;
        end else begin
            setup_q_r <= active_setup;
        end
    end

    // Counts cycles with the port deselected and the setup index unchanged.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            idle_cnt_r <= 4'h0;
        end else if (!cs_n || active_setup != setup_q_r) begin
            idle_cnt_r <= 4'h0;
        end else if (idle_cnt_r != 4'hF) begin
            idle_cnt_r <= idle_cnt_r + 4'h1;
        end
    end

    sequence s_recent_select;
        !$past(cs_n, 1) || !$past(cs_n, 2) || !$past(cs_n, 3) || !$past(cs_n, 4);
    endsequence
    sequence s_held_off;
        cs_n [*6];
    endsequence

    a_oe_on_select: assert property ($fell(cs_n) |-> ##[1:5] sdo_oe)
        else $error("output enable missing after select");
    a_oe_off_deselect: assert property ($rose(cs_n) |-> ##[1:5] !sdo_oe)
        else $error("output enable stays after deselect");
    a_oe_held_off: assert property (s_held_off |-> !sdo_oe)
        else $error("output driven while deselected");
    a_oe_has_cause: assert property (sdo_oe |-> s_recent_select)
        else $error("output enable without select");
    a_ctl_idle_stable: assert property (idle_cnt_r == 4'hF |->
        $stable({ctl.in_ground, ctl.guard_on, ctl.ref_range, ctl.rate_scale, ctl.osc_bank}))
        else $error("controls changed while port idle");
    a_pins_idle_stable: assert property (idle_cnt_r == 4'hF |->
        $stable({latch_output_pins, cal_sel, guard_drive}))
        else $error("latch or bank outputs changed while idle");
    a_power_mode_excl: assert property (ctl.sleep |-> !ctl.standby)
        else $error("sleep and standby together");
    a_guard_follow: assert property ($rose(ctl.guard_on) |-> ##[0:3] guard_drive)
        else $error("guard output not driven");
endmodule : ascc_checker

bind ascc_ctrl ascc_checker #(.OSC_WAIT(OSC_WAIT)) ascc_checker_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .cs_n(cs_n), .active_setup(active_setup),
    .sdo_oe(sdo_oe), .latch_output_pins(latch_output_pins), .cal_sel(cal_sel),
    .guard_drive(guard_drive), .ctl(ctl)
);
`default_nettype wire

// file: testbench/ascc_host.sv
// Host model that clocks commands and data through the serial port.
`timescale 1ns/10ps
`default_nettype none
module ascc_host (
    // Lines driven toward the device.
    output var logic sclk,
    output var logic cs_n,
    output var logic sdi,
    // Line returned by the device.
    input  wire logic sdo
);
    localparam int HALF = 24;

    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    task automatic frame_on();
        cs_n = 1'b0;
        #HALF;
    endtask : frame_on

    task automatic frame_off();
        #HALF;
        cs_n = 1'b1;
        sdi  = ~sdi;
        #HALF;
    endtask : frame_off

    // Data is set while the clock is low and read just before it rises.
    task automatic bit1(input logic b, output logic q);
        sdi = b;
        #HALF;
        q    = sdo;
        sclk = 1'b1;
        #HALF;
        sclk = 1'b0;
    endtask : bit1

    task automatic byte8(input logic [7:0] b);
        logic q;
        for (int i = 7; i >= 0; i--) begin
            bit1(b[i], q);
        end
    endtask : byte8

    task automatic word32(input logic [31:0] w, output logic [31:0] r);
        for (int i = 31; i >= 0; i--) begin
            bit1(w[i], r[i]);
        end
    endtask : word32
endmodule : ascc_host
`default_nettype wire

// file: testbench/tb.sv
// Self-checking bench of the serial command and configuration block.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import ascc_pkg::*;
    logic        sys_clk;
    logic        rst_n;
    logic        ext_clk_sel;
    logic [2:0]  active_setup;
    wire logic   sclk;
    wire logic   cs_n;
    wire logic   sdi;
    wire logic   sdo_pin;
    logic        sdo_o;
    logic        sdo_oe;
    logic        sdo_last;
    logic [1:0]  latch_output_pins;
    logic [1:0]  cal_sel;
    logic        guard_drive;
    ascc_ctl_t   ctl;
    logic [31:0] rw;
    logic [31:0] ofs [4];
    int          failures;
    int          n_checks;

    // A released output line floats to the opposite of its last level.
    assign sdo_pin = sdo_oe ? sdo_o : ~sdo_last;
    always @(posedge sys_clk) begin
        if (sdo_oe === 1'b1) begin
            sdo_last <= sdo_o;
        end
    end

    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    ascc_ctrl #(.OSC_WAIT(40)) ascc_ctrl_i (
        .sys_clk(sys_clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .ext_clk_sel(ext_clk_sel),
        .active_setup(active_setup), .conv_data(32'h0000_0000),
        .latch_output_pins(latch_output_pins), .guard_drive(guard_drive),
        .ctl(ctl), .cal_sel(cal_sel)
    );
    ascc_host ascc_host_i (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_pin));

    function automatic logic [7:0] cmdb(input logic a, input logic [1:0] i,
                                        input logic r, input logic [2:0] g);
        return {1'b0, a, i, r, g};
    endfunction : cmdb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle();
        repeat (12) @(posedge sys_clk);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] c, input logic [31:0] d);
        ascc_host_i.frame_on();
        ascc_host_i.byte8(c);
        ascc_host_i.word32(d, rw);
        ascc_host_i.frame_off();
        settle();
    endtask : wr

    task automatic rd(input logic [7:0] c, input logic [31:0] exp);
        wr(c, 32'h0000_0000);
        chk(rw, exp);
    endtask : rd

    task automatic summarize();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : summarize

    // Whole sequence takes well under a millisecond.
    initial begin
        #2_000_000;
        failures++;
        summarize();
    end

    initial begin
        failures = 0;
        n_checks = 0;
        rst_n = 1'b0;
        ext_clk_sel = 1'b0;
        active_setup = 3'h0;
        sdo_last = 1'b0;
        ofs = '{32'h0000_0001, 32'h8000_0000, 32'hFFFF_FFFE, 32'h1234_5678};
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge sys_clk);
        ascc_host_i.frame_on();
        ascc_host_i.byte8(cmdb(1'b1, 2'h0, 1'b1, GRP_GAIN));
        for (int i = 0; i < NREG; i++) begin
            ascc_host_i.word32(32'h0000_0000, rw);
            chk(rw, GAIN_RESET);
        end
        ascc_host_i.frame_off();
        settle();
        rd(cmdb(1'b0, 2'h3, 1'b1, GRP_SETUP), SETUP_RESET);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), CFG_RESET);
        ascc_host_i.frame_on();
        ascc_host_i.byte8(cmdb(1'b1, 2'h0, 1'b0, GRP_OFFSET));
        for (int i = 0; i < NREG; i++) begin
            ascc_host_i.word32(ofs[i], rw);
        end
        ascc_host_i.frame_off();
        settle();
        for (int i = NREG - 1; i >= 0; i--) begin
            rd(cmdb(1'b0, 2'(i), 1'b1, GRP_OFFSET), ofs[i]);
        end
        wr(cmdb(1'b0, 2'h2, 1'b0, GRP_GAIN), 32'h8000_0000);
        // Realign, flag clear and two reads under one held select.
        ascc_host_i.frame_on();
        ascc_host_i.byte8(CMD_LEAD);
        ascc_host_i.byte8(CMD_END);
        ascc_host_i.byte8(CMD_NULL);
        ascc_host_i.byte8(cmdb(1'b0, 2'h2, 1'b1, GRP_GAIN));
        ascc_host_i.word32(32'h0000_0000, rw);
        chk(rw, 32'h8000_0000);
        ascc_host_i.byte8(cmdb(1'b0, 2'h1, 1'b1, GRP_GAIN));
        ascc_host_i.word32(32'h0000_0000, rw);
        chk(rw, GAIN_RESET);
        ascc_host_i.frame_off();
        settle();
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_SETUP), 32'h4023_8010);
        chk({28'h0, latch_output_pins, cal_sel}, 32'h0000_0009);
        active_setup = 3'h1;
        settle();
        chk({28'h0, latch_output_pins, cal_sel}, 32'h0000_0006);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h08D8_0000);
        chk({28'h0, latch_output_pins, cal_sel}, 32'h0000_0004);
        active_setup = 3'h0;
        settle();
        chk({28'h0, latch_output_pins, cal_sel}, 32'h0000_0007);
        chk({28'h0, ctl.in_ground, ctl.guard_on, ctl.ref_range, ctl.rate_scale}, 32'h9);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), 32'h08D8_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h0400_0000);
        chk({26'h0, ctl.latch, ctl.osc_bank, ctl.guard_on, guard_drive}, 32'h0000_0007);
        // Clocking with the port deselected must change nothing.
        ascc_host_i.byte8(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG));
        ascc_host_i.word32(32'h0800_0000, rw);
        chk({31'h0, sdo_oe}, 32'h0000_0000);
        settle();
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), 32'h0400_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h4000_0000);
        chk({30'h0, ctl.sleep, ctl.standby}, 32'h0000_0001);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'hC000_0000);
        chk({30'h0, ctl.sleep, ctl.standby}, 32'h0000_0002);
        ext_clk_sel = 1'b1;
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h0000_0000);
        chk({30'h0, ctl.sleep, ctl.standby}, 32'h0000_0000);
        ext_clk_sel = 1'b0;
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'hC000_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h0000_0000);
        chk({30'h0, ctl.sleep, ctl.standby}, 32'h0000_0002);
        repeat (45) @(posedge sys_clk);
        chk({30'h0, ctl.sleep, ctl.standby}, 32'h0000_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h1000_0000);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), 32'h0000_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h2000_0000);
        wr(cmdb(1'b0, 2'h0, 1'b0, GRP_CONFIG), 32'h0000_0000);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), 32'h1000_0000);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_CONFIG), 32'h0000_0000);
        rd(cmdb(1'b0, 2'h1, 1'b1, GRP_OFFSET), OFS_RESET);
        rd(cmdb(1'b0, 2'h2, 1'b1, GRP_GAIN), GAIN_RESET);
        rd(cmdb(1'b0, 2'h0, 1'b1, GRP_SETUP), SETUP_RESET);
        summarize();
    end
endmodule : tb
`default_nettype wire
